// ### hw/monitor_mode_clear_flash_cmd.sv
`timescale 1ns/1ns
`include "monitor_regs.svh"
// Overview of operation
// - mode bit 7 picks pin direction: 1 input, 0 open-drain; resets to 0
// - mode bit 6 releases (1) or turns on (0) the open-drain driver; resets 1
// - time counter rollover past FFFFH sets its slow-time flag
// - mode bits 3..1 select wake threshold; sleep only below it after power-down
// - threshold resets to all ones; zero means sleep at once
// - mode bit 0 set on supply drop below POR; host may write it freely
// - clear bit 4 zeroes charge-time counter and its flag, then self-clears
// - clear bit 3 zeroes discharge-time counter and its flag, then self-clears
// - clear bit 2 zeroes self-discharge counter, then self-clears
// - clear bit 1 zeroes charge counter, then self-clears
// - clear bit 0 zeroes discharge counter, then self-clears
// - a written command code starts; register returns to zero when finished
// - code 0F ANDs program data into flash byte at program address
// - codes 40, 41, 42 erase flash pages 00-1F, 20-3F, 40-5F
// - code 45 programs the RAM into flash page 0
// - code 48 copies flash page 0 into the RAM
// - code F6 enters sleep once the wake threshold condition holds
// - sleep lasts until the serial line shows any edge
// - clearing a time counter restores its default count rate
// - command byte MSB 1 writes the following byte, 0 reads
// - the mode register sits at address 64
module monitor_mode_clear_flash_cmd (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire monitor_pkg::byte_t cmd_byte,
  input wire monitor_pkg::byte_t cmd_wdata,
  output monitor_pkg::byte_t read_data,
  output logic read_valid,
  input wire logic single_wire_serial_line,
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe,
  input wire logic supply_below_por,
  input wire logic sense_below_threshold,
  output logic [2:0] wake_threshold_select,
  input wire logic charge_time_rollover,
  input wire logic discharge_time_rollover,
  output logic [4:0] counter_clear_pulse,
  output logic asleep
);
  import monitor_pkg::*;

  monitor_state_t s;
  monitor_state_t next_s;
  logic next_line_lvl;
  logic line_edge;

  // =============================================================
  // helpers
  // a level change counts once the two older flops agree
  function automatic logic filtered(input logic [2:0] sync, input logic lvl);
    filtered = (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction : filtered

  function automatic byte_t read_reg(input logic [6:0] addr, input monitor_state_t st);
    byte_t v;
    v = 8'h00;
    case (addr)
      `ADDR_MODE: begin
        v = st.mode;
        // an input pin reads back its level in the driver bit
        if (st.mode[`MODE_PIN_DIRECTION]) begin
          v[`MODE_PIN_RELEASE] = st.gpio_lvl;
        end
      end
      `ADDR_COUNTER_CLEAR: v = {3'h0, st.clr};
      `ADDR_FLASH_COMMAND: v = st.cmd;
      `ADDR_PROGRAM_DATA: v = st.pdata;
      `ADDR_PROGRAM_ADDRESS: v = st.paddr;
      default: begin
        if (addr <= `ADDR_FLASH_LAST) begin
          v = st.flash[addr];
        end
      end
    endcase
    read_reg = v;
  endfunction : read_reg

  function automatic monitor_state_t reset_state();
    monitor_state_t r;
    r = '0;
    r.st = ST_IDLE;
    r.mode = `MODE_RESET;
    r.clr = `CLR_RESET;
    r.flash = {`FLASH_BYTES{`ERASED_BYTE}};
    // the serial line idles high, so no false wake edge follows reset
    r.line_sync = 3'h7;
    r.line_lvl = 1'b1;
    return r;
  endfunction : reset_state

  // =============================================================
  // next state
  always_comb begin
    logic [6:0] addr;
    logic [6:0] fidx;
    logic [1:0] pg;
    addr = cmd_byte[6:0];
    fidx = 7'h00;
    pg = 2'h0;
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.clear_pulse = 5'h00;
    next_s.line_sync = {s.line_sync[1:0], single_wire_serial_line};
    next_s.gpio_sync = {s.gpio_sync[1:0], gpio_in};
    next_s.por_sync = {s.por_sync[1:0], supply_below_por};
    next_s.sense_sync = {s.sense_sync[1:0], sense_below_threshold};
    next_line_lvl = filtered(s.line_sync, s.line_lvl);
    line_edge = next_line_lvl != s.line_lvl;
    next_s.line_lvl = next_line_lvl;
    next_s.gpio_lvl = filtered(s.gpio_sync, s.gpio_lvl);
    next_s.sense_lvl = filtered(s.sense_sync, s.sense_lvl);

    // counter clears: one strobe, then the bits fall back to zero
    // all five clear bits strobe; the two time clears also drop their slow flags
    if (s.clr != 5'h00) begin
      next_s.clear_pulse = s.clr;
      next_s.clr = 5'h00;
    end
    if (s.clr[`CLR_CHARGE_TIME]) begin
      next_s.mode[`MODE_SLOW_CHARGE] = 1'b0;
    end
    if (s.clr[`CLR_DISCHARGE_TIME]) begin
      next_s.mode[`MODE_SLOW_DISCHARGE] = 1'b0;
    end

    // command byte decode; the line is not served while asleep
    if (cmd_valid && s.st != ST_SLEEP) begin
      if (cmd_byte[`CMD_WRITE_BIT]) begin
        case (addr)
          `ADDR_MODE: next_s.mode = cmd_wdata;
          `ADDR_COUNTER_CLEAR: next_s.clr = cmd_wdata[4:0];
          `ADDR_FLASH_COMMAND: begin
            // a busy engine ignores a new code
            if (s.st == ST_IDLE && s.cmd == `FC_NONE) begin
              next_s.cmd = cmd_wdata;
            end
          end
          `ADDR_PROGRAM_DATA: next_s.pdata = cmd_wdata;
          `ADDR_PROGRAM_ADDRESS: next_s.paddr = cmd_wdata;
          default: begin
            if (addr <= `ADDR_RAM_LAST) begin
              next_s.ram[addr[4:0]] = cmd_wdata;
            end
          end
        endcase
      end else begin
        next_s.rdata = read_reg(addr, s);
        next_s.rvalid = 1'b1;
      end
    end

    // hardware events win over a host write in the same cycle
    // rollover flags
    if (charge_time_rollover) begin
      next_s.mode[`MODE_SLOW_CHARGE] = 1'b1;
    end
    if (discharge_time_rollover) begin
      next_s.mode[`MODE_SLOW_DISCHARGE] = 1'b1;
    end
    // supply drop marks the POR flag
    if (s.por_sync[1] && s.por_sync[2]) begin
      next_s.mode[`MODE_POR] = 1'b1;
    end

    // =============================================================
    // flash command engine
    case (s.st)
      ST_IDLE: begin
        // a nonzero code starts the engine
        if (s.cmd != `FC_NONE) begin
          next_s.st = ST_EXEC;
          next_s.idx = 5'h00;
        end
      end
      ST_EXEC: begin
        next_s.idx = s.idx + 5'h01;
        case (s.cmd)
          `FC_PROGRAM_BYTE: begin
            if (s.paddr < 8'(`FLASH_BYTES)) begin
              next_s.flash[s.paddr[6:0]] = s.flash[s.paddr[6:0]] & s.pdata;
            end
            next_s.cmd = `FC_NONE;
            next_s.st = ST_IDLE;
          end
          `FC_ERASE_PAGE0, `FC_ERASE_PAGE1, `FC_ERASE_PAGE2: begin
            // page erase, one byte a cycle
            pg = s.cmd[1:0];
            fidx = {pg, s.idx};
            next_s.flash[fidx] = `ERASED_BYTE;
          end
          `FC_RAM_TO_FLASH: begin
            next_s.flash[s.idx] = s.flash[s.idx] & s.ram[s.idx];
          end
          `FC_FLASH_TO_RAM: begin
            next_s.ram[s.idx] = s.flash[s.idx];
          end
          `FC_POWER_DOWN: next_s.st = ST_WAIT;
          default: begin
            next_s.cmd = `FC_NONE;
            next_s.st = ST_IDLE;
          end
        endcase
        // page-wide operations finish after the last byte
        if (s.idx == `PAGE_LAST && s.st == ST_EXEC && next_s.st == ST_EXEC &&
            s.cmd != `FC_POWER_DOWN) begin
          next_s.cmd = `FC_NONE;
          next_s.st = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // sleep only below the selected threshold
        // a zero threshold sleeps at once
        if (s.mode[`MODE_WAKE_HI:`MODE_WAKE_LO] == 3'h0 || s.sense_lvl) begin
          next_s.st = ST_SLEEP;
          next_s.cmd = `FC_NONE;
        end
      end
      ST_SLEEP: begin
        // either edge on the line wakes
        if (line_edge) begin
          next_s.st = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    next_s.asleep = next_s.st == ST_SLEEP;

    // open-drain pulls low only when output and not released
    next_s.gpio_oe = !next_s.mode[`MODE_PIN_DIRECTION] && !next_s.mode[`MODE_PIN_RELEASE];
    next_s.gpio_out = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  // =============================================================
  // outputs
  assign read_data = s.rdata;
  assign read_valid = s.rvalid;
  assign gpio_out = s.gpio_out;
  assign gpio_oe = s.gpio_oe;
  assign wake_threshold_select = s.mode[`MODE_WAKE_HI:`MODE_WAKE_LO];
  // time-counter clear strobes also restore the default rate outside
  assign counter_clear_pulse = s.clear_pulse;
  assign asleep = s.asleep;

  // =============================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] prog_old;
  assign prog_old = (s.paddr < 8'(`FLASH_BYTES)) ? s.flash[s.paddr[6:0]] : 8'h00;

  sequence clear_write_s;
    cmd_valid && s.st != ST_SLEEP && cmd_byte == {1'b1, `ADDR_COUNTER_CLEAR} &&
      cmd_wdata[`CLR_CHARGE_TIME];
  endsequence
  sequence clear_done_s;
    s.clr[`CLR_CHARGE_TIME] ##1 (counter_clear_pulse[`CLR_CHARGE_TIME] &&
      !s.clr[`CLR_CHARGE_TIME] && !s.mode[`MODE_SLOW_CHARGE]);
  endsequence
  sequence erase1_start_s;
    s.st == ST_IDLE && s.cmd == `FC_ERASE_PAGE1;
  endsequence

  pin_driver_a: assert property (gpio_oe == (!s.mode[7] && !s.mode[6]))
    else $error("open-drain enable does not follow mode bits");
  rollover_flag_a: assert property (charge_time_rollover |=> s.mode[5])
    else $error("charge-time rollover did not set its flag");
  charge_clear_a: assert property (clear_write_s ##1 !cmd_valid &&
      !charge_time_rollover |-> ##0 clear_done_s)
    else $error("charge-time clear did not strobe and self-clear");
  discharge_flag_a: assert property (s.clr[3] && !discharge_time_rollover |=>
      !s.mode[4] && counter_clear_pulse[3])
    else $error("discharge-time clear left its flag set");
  count_clear_a: assert property (s.clr[2:0] != 3'h0 && !cmd_valid |=>
      counter_clear_pulse[2:0] == $past(s.clr[2:0]) && s.clr[2:0] == 3'h0)
    else $error("counter clear strobe wrong or bit stuck");
  program_byte_a: assert property (s.st == ST_EXEC && s.cmd == `FC_PROGRAM_BYTE &&
      s.paddr < 8'h60 |=> s.flash[$past(s.paddr[6:0])] == ($past(prog_old) & $past(s.pdata))
      && s.cmd == `FC_NONE)
    else $error("program byte result wrong");
  page_erase_a: assert property (erase1_start_s |-> ##33 (s.cmd == `FC_NONE &&
      s.flash[32] == 8'hFF && s.flash[63] == 8'hFF))
    else $error("page 1 erase incomplete after 32 bytes");
  zero_wake_a: assert property (s.st == ST_WAIT &&
      wake_threshold_select == 3'h0 |=> asleep && s.cmd == `FC_NONE)
    else $error("zero threshold did not sleep at once");
  stay_asleep_a: assert property (asleep && !line_edge |=> asleep)
    else $error("left sleep without a line edge");
  unknown_cmd_a: assert property (s.st == ST_EXEC &&
      !(s.cmd inside {`FC_PROGRAM_BYTE, `FC_ERASE_PAGE0, `FC_ERASE_PAGE1, `FC_ERASE_PAGE2,
      `FC_RAM_TO_FLASH, `FC_FLASH_TO_RAM, `FC_POWER_DOWN}) |=> s.cmd == `FC_NONE &&
      s.st == ST_IDLE && $stable(s.flash))
    else $error("unknown command acted or stayed");
  mode_read_a: assert property (cmd_valid && s.st != ST_SLEEP && cmd_byte == 8'h64 &&
      !s.mode[7] |=> read_valid && read_data == $past(s.mode))
    else $error("mode read returned wrong data");

  // =============================================================
  // engine, flag and sleep checks
  por_flag_a: assert property (s.por_sync[1] && s.por_sync[2] |=> s.mode[0])
    else $error("supply drop did not set the reset flag");
  sleep_hold_a: assert property (s.st == ST_WAIT && wake_threshold_select != 3'h0 &&
      !s.sense_lvl |=> !asleep && s.cmd == `FC_POWER_DOWN)
    else $error("slept above the wake threshold");
  wake_edge_a: assert property (asleep && line_edge |=> !asleep)
    else $error("line edge did not wake");
  ram_program_a: assert property (s.st == ST_EXEC && s.cmd == `FC_RAM_TO_FLASH |=>
      s.flash[$past(s.idx)] == ($past(s.flash[s.idx]) & $past(s.ram[s.idx])))
    else $error("ram byte not programmed into flash");
  ram_copy_a: assert property (s.st == ST_EXEC && s.cmd == `FC_FLASH_TO_RAM |=>
      s.ram[$past(s.idx)] == $past(s.flash[s.idx]))
    else $error("flash byte not copied into ram");
  busy_refuse_a: assert property (s.st != ST_IDLE && cmd_valid &&
      cmd_byte == {1'b1, `ADDR_FLASH_COMMAND} |=> s.cmd == $past(s.cmd) || s.cmd == `FC_NONE)
    else $error("busy engine took a new command");
endmodule : monitor_mode_clear_flash_cmd

// ### hw/monitor_pkg.sv
`include "monitor_regs.svh"
package monitor_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11,
    ST_SLEEP = 2'b10
  } cmd_state_t;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    cmd_state_t st;
    byte_t mode;
    logic [4:0] clr;
    byte_t cmd;
    byte_t pdata;
    byte_t paddr;
    logic [4:0] idx;
    logic [`FLASH_BYTES-1:0][7:0] flash;
    logic [`RAM_BYTES-1:0][7:0] ram;
    logic [4:0] clear_pulse;
    byte_t rdata;
    logic rvalid;
    logic gpio_oe;
    logic gpio_out;
    logic asleep;
    logic [2:0] line_sync;
    logic line_lvl;
    logic [2:0] gpio_sync;
    logic gpio_lvl;
    logic [2:0] por_sync;
    logic [2:0] sense_sync;
    logic sense_lvl;
  } monitor_state_t;
endpackage : monitor_pkg

// ### hw/monitor_regs.svh
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH
// =============================================================
// register addresses (7-bit field of the command byte)
`define ADDR_FLASH_COMMAND 7'h62
`define ADDR_COUNTER_CLEAR 7'h63
`define ADDR_MODE 7'h64
`define ADDR_PROGRAM_DATA 7'h6F
`define ADDR_PROGRAM_ADDRESS 7'h70
`define ADDR_RAM_LAST 7'h1F
`define ADDR_FLASH_LAST 7'h5F
// =============================================================
// command byte fields
`define CMD_WRITE_BIT 7
// =============================================================
// mode register fields
`define MODE_PIN_DIRECTION 7
`define MODE_PIN_RELEASE 6
`define MODE_SLOW_CHARGE 5
`define MODE_SLOW_DISCHARGE 4
`define MODE_WAKE_HI 3
`define MODE_WAKE_LO 1
`define MODE_POR 0
`define MODE_RESET 8'h4F
// =============================================================
// clear register fields
`define CLR_CHARGE_TIME 4
`define CLR_DISCHARGE_TIME 3
`define CLR_SELF_DISCHARGE 2
`define CLR_CHARGE 1
`define CLR_DISCHARGE 0
`define CLR_RESET 5'h00
// =============================================================
// flash command codes
`define FC_NONE 8'h00
`define FC_PROGRAM_BYTE 8'h0F
`define FC_ERASE_PAGE0 8'h40
`define FC_ERASE_PAGE1 8'h41
`define FC_ERASE_PAGE2 8'h42
`define FC_RAM_TO_FLASH 8'h45
`define FC_FLASH_TO_RAM 8'h48
`define FC_POWER_DOWN 8'hF6
// =============================================================
// memory sizes
`define FLASH_BYTES 96
`define RAM_BYTES 32
`define PAGE_LAST 5'h1F
`define ERASED_BYTE 8'hFF
`endif

// ### tb/monitor_mode_clear_flash_cmd_tb_top.sv
`timescale 1ns/1ns
`include "monitor_regs.svh"
module monitor_mode_clear_flash_cmd_tb_top;
  import monitor_pkg::*;
  logic mclk, rst, cmd_valid, read_valid, single_wire_serial_line, gpio_in, gpio_out, gpio_oe;
  logic supply_below_por, sense_below_threshold, charge_time_rollover, discharge_time_rollover;
  logic asleep;
  byte_t cmd_byte, cmd_wdata, read_data, v, w;
  byte_t r[3];
  byte_t exp_q[$];
  logic [2:0] wake_threshold_select;
  logic [4:0] counter_clear_pulse;
  int fails, tests_run, seed;

  monitor_mode_clear_flash_cmd u_monitor_mode_clear_flash_cmd (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .read_data(read_data),
    .read_valid(read_valid), .single_wire_serial_line(single_wire_serial_line),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .supply_below_por(supply_below_por), .sense_below_threshold(sense_below_threshold),
    .wake_threshold_select(wake_threshold_select), .charge_time_rollover(charge_time_rollover),
    .discharge_time_rollover(discharge_time_rollover),
    .counter_clear_pulse(counter_clear_pulse), .asleep(asleep));

  serial_host_model u_serial_host_model (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata),
    .single_wire_serial_line(single_wire_serial_line));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // =============================================================
  // helpers
  task automatic chk(input byte_t got, input byte_t exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input byte_t d);
    u_serial_host_model.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a, input byte_t e);
    exp_q.push_back(e);
    u_serial_host_model.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic prog(input byte_t a, input byte_t d);
    wr(`ADDR_PROGRAM_ADDRESS, a);
    wr(`ADDR_PROGRAM_DATA, d);
    wr(`ADDR_FLASH_COMMAND, `FC_PROGRAM_BYTE);
    cyc(4);
  endtask : prog
  task automatic run_cmd(input byte_t c);
    wr(`ADDR_FLASH_COMMAND, c);
    cyc(40);
  endtask : run_cmd
  task automatic pulse_chk(input int i);
    logic [4:0] seen;
    seen = 5'h00;
    repeat (6) begin
      @(negedge mclk);
      seen = seen | counter_clear_pulse;
    end
    chk({3'h0, seen}, 8'(1 << i), "clear strobe");
  endtask : pulse_chk
  task automatic wrap_up();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // read answers are matched against the oldest note
  always @(negedge mclk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(read_data, 8'hXX, "unexpected read");
      else chk(read_data, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    #200000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    wrap_up();
  end

  // =============================================================
  // main sequence
  initial begin
    seed = 97051;
    rst = 1'b1;
    gpio_in = 1'b0;
    supply_below_por = 1'b0;
    sense_below_threshold = 1'b0;
    charge_time_rollover = 1'b0;
    discharge_time_rollover = 1'b0;
    cyc(8);
    rst = 1'b0;
    rd(`ADDR_MODE, `MODE_RESET);
    rd(`ADDR_COUNTER_CLEAR, 8'h00);
    rd(`ADDR_FLASH_COMMAND, 8'h00);
    chk({7'h0, gpio_oe}, 8'h00, "oe reset");
    chk({5'h0, wake_threshold_select}, 8'h07, "threshold reset");
    wr(`ADDR_MODE, 8'h0E);
    cyc(2);
    chk({7'h0, gpio_oe}, 8'h01, "driver on");
    rd(`ADDR_MODE, 8'h0E);
    gpio_in = 1'($random(seed));
    wr(`ADDR_MODE, 8'h8E);
    cyc(6);
    chk({7'h0, gpio_oe}, 8'h00, "input mode");
    rd(`ADDR_MODE, {1'b1, gpio_in, 6'h0E});
    wr(`ADDR_MODE, 8'h4E);
    supply_below_por = 1'b1;
    cyc(6);
    supply_below_por = 1'b0;
    charge_time_rollover = 1'b1;
    cyc(1);
    charge_time_rollover = 1'b0;
    discharge_time_rollover = 1'b1;
    cyc(1);
    discharge_time_rollover = 1'b0;
    rd(`ADDR_MODE, 8'h7F);
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_COUNTER_CLEAR, 8'(1 << i));
      pulse_chk(i);
    end
    rd(`ADDR_COUNTER_CLEAR, 8'h00);
    rd(`ADDR_MODE, 8'h4F);
    for (int p = 0; p < 3; p++) begin
      r[p] = byte_t'($random(seed));
      prog(8'(p * 32 + 5), r[p]);
      rd(7'(p * 32 + 5), r[p]);
    end
    v = byte_t'($random(seed));
    prog(8'h25, v);
    r[1] = r[1] & v;
    rd(7'h25, r[1]);
    for (int p = 0; p < 3; p++) begin
      run_cmd(8'(`FC_ERASE_PAGE0 + p));
      rd(7'(p * 32 + 5), `ERASED_BYTE);
      if (p < 2) rd(7'(p * 32 + 37), r[p + 1]);
      rd(`ADDR_FLASH_COMMAND, 8'h00);
    end
    wr(7'h03, v);
    run_cmd(`FC_RAM_TO_FLASH);
    rd(7'h03, v);
    rd(7'h1F, 8'h00);
    w = byte_t'($random(seed)) | 8'h01;
    run_cmd(`FC_ERASE_PAGE0);
    prog(8'h04, w);
    run_cmd(`FC_FLASH_TO_RAM);
    run_cmd(`FC_ERASE_PAGE0);
    run_cmd(`FC_RAM_TO_FLASH);
    rd(7'h04, w);
    wr(`ADDR_FLASH_COMMAND, 8'h33);
    cyc(6);
    rd(`ADDR_FLASH_COMMAND, 8'h00);
    rd(7'h04, w);
    wr(7'h7E, 8'h55);
    rd(7'h7E, 8'h00);
    wr(`ADDR_MODE, 8'h42);
    cyc(2);
    chk({5'h0, wake_threshold_select}, 8'h01, "threshold out");
    wr(`ADDR_FLASH_COMMAND, `FC_POWER_DOWN);
    cyc(10);
    chk({7'h0, asleep}, 8'h00, "above threshold");
    wr(`ADDR_FLASH_COMMAND, `FC_ERASE_PAGE0);
    rd(`ADDR_FLASH_COMMAND, `FC_POWER_DOWN);
    sense_below_threshold = 1'b1;
    cyc(8);
    chk({7'h0, asleep}, 8'h01, "sleep entry");
    wr(`ADDR_MODE, 8'h4E);
    u_serial_host_model.wake();
    cyc(8);
    chk({7'h0, asleep}, 8'h00, "woken");
    rd(`ADDR_MODE, 8'h42);
    rd(`ADDR_FLASH_COMMAND, 8'h00);
    wr(`ADDR_MODE, 8'h40);
    sense_below_threshold = 1'b0;
    wr(`ADDR_FLASH_COMMAND, `FC_POWER_DOWN);
    cyc(8);
    chk({7'h0, asleep}, 8'h01, "zero threshold");
    u_serial_host_model.wake();
    cyc(8);
    chk({7'h0, asleep}, 8'h00, "woken again");
    cyc(4);
    chk(8'(exp_q.size()), 8'h00, "missing answers");
    wrap_up();
  end
endmodule : monitor_mode_clear_flash_cmd_tb_top

// ### tb/serial_host_model.sv
`timescale 1ns/1ns
`include "monitor_regs.svh"
// =============================================================
// host controller on the serial line, one decoded byte pair per access
module serial_host_model (
  input wire logic mclk,
  output logic cmd_valid,
  output monitor_pkg::byte_t cmd_byte,
  output monitor_pkg::byte_t cmd_wdata,
  output logic single_wire_serial_line
);
  import monitor_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_wdata = 8'h00;
    single_wire_serial_line = 1'b1;
  end
  task automatic access(input logic wr, input logic [6:0] addr, input byte_t data);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_byte = {wr, addr};
    cmd_wdata = (wr && addr == `ADDR_COUNTER_CLEAR) ? (data & 8'h1F) : data;
    @(negedge mclk);
    cmd_valid = 1'b0;
    // released bytes must not keep looking valid
    cmd_byte = ~cmd_byte;
    cmd_wdata = ~cmd_wdata;
  endtask : access
  task automatic wake();
    @(negedge mclk);
    single_wire_serial_line = ~single_wire_serial_line;
  endtask : wake
endmodule : serial_host_model
